// [hdl/cosc_map.svh]
`ifndef COSC_MAP_SVH
`define COSC_MAP_SVH
// register byte addresses
`define COSC_OFS_CHAN_CFG0 12'h028
`define COSC_OFS_SELF_TEST 12'h00C
`define COSC_OFS_SW_RESET 12'h012
`define COSC_OFS_GEN_TEST 12'h100
`define COSC_OFS_CHAN_TEST0 12'h104
`define COSC_OFS_CONTROL 12'h120
`define COSC_OFS_LAMP 12'h124
`define COSC_OFS_DISCONNECT 12'h128
`define COSC_OFS_CLOCK_SEL 12'h12C
`define COSC_OFS_CAL_MUX 12'h130
`define COSC_OFS_IRQ_STATUS 12'h134
`define COSC_OFS_IRQ_MASK 12'h138
`define COSC_OFS_STATE 12'h13C
// field positions
`define COSC_CFG_MARK_POL 0
`define COSC_CTL_SELF_TEST 0
`define COSC_CTL_CAL 1
`define COSC_CTL_CAL_END 2
`define COSC_CTL_PLAY 4
`define COSC_LAMP_FORCE 0
`define COSC_LAMP_VALUE 1
// reset values and calibration read value
`define COSC_SW_RESET_VAL 16'h001D
`define COSC_CAL_READ_VAL 32'h0000_3C00
`define COSC_CFG_RESET 16'h0000
// timing
`define COSC_CLK_MHZ 125
`define COSC_BLINK_MS 250
`define COSC_BLINK_CYC (`COSC_BLINK_MS * `COSC_CLK_MHZ * 1000)
`define COSC_TEST_CYC 64
`endif

// [hdl/cosc_pkg.sv]
package cosc_pkg;
  typedef enum logic [3:0] {
    TEST_IDLE = 4'b0001,
    TEST_RUN = 4'b0010,
    TEST_CAL = 4'b0100,
    TEST_DONE = 4'b1000
  } cosc_test_e;
  typedef struct packed {
    logic [3:0] marker;
    logic [3:0] connect;
    logic [3:0] clockMon;
    logic lamp;
  } cosc_front_s;
  typedef struct packed {
    logic [3:0] load;
    logic [63:0] code;
  } cosc_dac_s;
endpackage

// [hdl/cosc_channel_output_status_control.sv]
// Summary of operation
// RULE1: reset takes channels offline, defaults, self-test
// RULE2: reset loads software reset register 0x1D
// RULE3: self-test on reset and on command
// RULE4: one pass/fail bit per channel
// RULE5: general fault separate from channel faults
// RULE6: one-cycle marker at first waveform sample
// RULE7: marker polarity from channel config bit
// RULE8: lamp on at reset, off after pass
// RULE9: lamp blinks during calibration or test; the code blinks only for a commanded test, the reset test keeps the lamp solid
// RULE10: software can force lamp on or off
// RULE11: per-channel field disconnect bit
// RULE12: per-channel external sample clock choice
// RULE13: internal sample clock driven to monitor
// RULE14: converter takes 16-bit word per channel
// RULE15: offset binary codes passed unchanged
// RULE16: calibration mux selects exactly one channel
// RULE17: calibration reads 0x3C00, writes dropped
// RULE18: marker aligned to selected sample clock
`include "cosc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module cosc_channel_output_status_control #(
  parameter int CHANNELS = 4,
  parameter int BLINK_CYC = `COSC_BLINK_CYC,
  parameter int TEST_CYC = `COSC_TEST_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // waveform buffers, one 16-bit word per channel
  input wire logic [63:0] bufWord,
  input wire logic [3:0] firstSample,
  output logic [3:0] sampleTake,
  // external sample clocks from the front connector
  input wire logic [3:0] extClkPin,
  // self-test results from the test engine
  input wire logic [3:0] chanFault,
  input wire logic genFault,
  // outputs
  output cosc_pkg::cosc_dac_s dacOut,
  output cosc_pkg::cosc_front_s front,
  output logic [1:0] calMuxSel,
  output logic irq
);
  import cosc_pkg::*;

  // refused at elaboration, the decode is fixed at four
  if (CHANNELS != 4) begin : genBadChan
    $error("only four channels supported");
  end
  if (BLINK_CYC < 2 || TEST_CYC < 2) begin : genBadCount
    $error("counts too small");
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  logic wrEn;
  logic rdEn;
  logic calActive;
  logic cmdRun_reg;
  logic [15:0] cfg_reg [4];
  logic [15:0] swReset_reg;
  logic [3:0] selfTest_reg;
  logic genTest_reg;
  logic [3:0] lamp_reg;
  logic [3:0] disc_reg;
  logic [3:0] clkSel_reg;
  logic [1:0] calMux_reg;
  logic [3:0] play_reg;
  logic [2:0] irqStat_reg;
  logic [2:0] irqMask_reg;
  cosc_test_e state_reg;
  logic [31:0] testCnt_reg;
  logic [31:0] blinkCnt_reg;
  logic blink_reg;
  logic [3:0] extS1_reg, extS2_reg, extS3_reg;
  logic [7:0] divCnt_reg;
  logic [3:0] intClk_reg;
  logic [3:0] tick;
  logic [3:0] marker_reg;
  logic [63:0] code_reg;
  logic [3:0] take_reg;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // calibration drops writes
  assign wrEn = psel && penable && pwrite && !calActive;
  assign rdEn = psel && !penable && !pwrite;
  assign calActive = state_reg == TEST_CAL;

  // RULE2: reset marker value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swReset_reg <= `COSC_SW_RESET_VAL;
    end else if (wrEn && hit(paddr, `COSC_OFS_SW_RESET)) begin
      swReset_reg <= pwdata[15:0];
    end
  end

  // RULE7: config registers hold polarity
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) cfg_reg[i] <= `COSC_CFG_RESET;
    end else begin
      for (int i = 0; i < 4; i++)
        if (wrEn && hit(paddr, 12'(`COSC_OFS_CHAN_CFG0 + 2 * i)))
          cfg_reg[i] <= pwdata[15:0];
    end
  end

  // RULE10: lamp override register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lamp_reg <= 4'h0;
    end else if (wrEn && hit(paddr, `COSC_OFS_LAMP)) begin
      lamp_reg <= pwdata[3:0];
    end
  end

  // RULE1: offline after reset
  // RULE11: per-channel disconnect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      disc_reg <= 4'hF;
    end else if (wrEn && hit(paddr, `COSC_OFS_DISCONNECT)) begin
      disc_reg <= pwdata[3:0];
    end
  end

  // RULE12: external clock select
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkSel_reg <= 4'h0;
    end else if (wrEn && hit(paddr, `COSC_OFS_CLOCK_SEL)) begin
      clkSel_reg <= pwdata[3:0];
    end
  end

  // RULE16: one channel encoded
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      calMux_reg <= 2'h0;
    end else if (wrEn && hit(paddr, `COSC_OFS_CAL_MUX)) begin
      calMux_reg <= pwdata[1:0];
    end
  end

  // play bits, cleared at reset so channels start idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      play_reg <= 4'h0;
    end else if (wrEn && hit(paddr, `COSC_OFS_CONTROL)) begin
      play_reg <= pwdata[`COSC_CTL_PLAY +: 4];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqMask_reg <= 3'h0;
    end else if (wrEn && hit(paddr, `COSC_OFS_IRQ_MASK)) begin
      irqMask_reg <= pwdata[2:0];
    end
  end

  // RULE9: command test blinks lamp
  // the reset test keeps the lamp solid instead
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmdRun_reg <= 1'b0;
    end else if (state_reg != TEST_RUN) begin
      cmdRun_reg <= wrEn && hit(paddr, `COSC_OFS_CONTROL)
        && pwdata[`COSC_CTL_SELF_TEST];
    end
  end

  // test sequencer; calibration end comes from the onboard processor
  // RULE3: start on reset or command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= TEST_RUN;
      testCnt_reg <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        TEST_IDLE, TEST_DONE: begin
          testCnt_reg <= 32'h0000_0000;
          if (wrEn && hit(paddr, `COSC_OFS_CONTROL)) begin
            if (pwdata[`COSC_CTL_SELF_TEST]) state_reg <= TEST_RUN;
            else if (pwdata[`COSC_CTL_CAL]) state_reg <= TEST_CAL;
          end
        end
        TEST_RUN: begin
          testCnt_reg <= testCnt_reg + 32'h0000_0001;
          if (testCnt_reg == 32'(TEST_CYC - 1)) state_reg <= TEST_DONE;
        end
        TEST_CAL: begin
          if (psel && penable && pwrite && hit(paddr, `COSC_OFS_CONTROL)
              && pwdata[`COSC_CTL_CAL_END])
            state_reg <= TEST_DONE;
        end
        default: state_reg <= TEST_IDLE;
      endcase
    end
  end

  // RULE4: per-channel result bits
  // RULE5: general fault kept apart
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selfTest_reg <= 4'h0;
      genTest_reg <= 1'b0;
    end else if (state_reg == TEST_RUN && testCnt_reg == 32'(TEST_CYC - 1)) begin
      selfTest_reg <= ~chanFault;
      genTest_reg <= genFault;
    end
  end

  // events: test done, test failed, calibration done; set wins over clear
  logic [2:0] evt;
  assign evt[0] = state_reg == TEST_RUN && testCnt_reg == 32'(TEST_CYC - 1);
  assign evt[1] = evt[0] && (genFault || |chanFault);
  assign evt[2] = calActive && psel && penable && pwrite
    && hit(paddr, `COSC_OFS_CONTROL) && pwdata[`COSC_CTL_CAL_END];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) irqStat_reg <= 3'h0;
    else begin
      for (int i = 0; i < 3; i++)
        if (evt[i]) irqStat_reg[i] <= 1'b1;
        else if (wrEn && hit(paddr, `COSC_OFS_IRQ_STATUS) && pwdata[i])
          irqStat_reg[i] <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end

  // RULE9: blink for calibration or commanded test
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blinkCnt_reg <= 32'h0000_0000;
      blink_reg <= 1'b1;
    end else if (blinkCnt_reg == 32'(BLINK_CYC - 1)) begin
      blinkCnt_reg <= 32'h0000_0000;
      blink_reg <= ~blink_reg;
    end else blinkCnt_reg <= blinkCnt_reg + 32'h0000_0001;
  end

  // lamp after a failed test stays lit
  logic lampAuto;
  always_comb begin
    unique case (state_reg)
      // RULE8: lit until pass
      TEST_RUN: lampAuto = cmdRun_reg ? blink_reg : 1'b1;
      TEST_CAL: lampAuto = blink_reg;
      TEST_DONE: lampAuto = genTest_reg || selfTest_reg != 4'hF;
      default: lampAuto = 1'b0;
    endcase
  end

  // RULE12: two-flop sync of pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extS1_reg <= 4'h0;
      extS2_reg <= 4'h0;
      extS3_reg <= 4'h0;
    end else begin
      extS1_reg <= extClkPin;
      extS2_reg <= extS1_reg;
      extS3_reg <= extS2_reg;
    end
  end

  // internal sample clock, divided down from clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_reg <= 8'h00;
      intClk_reg <= 4'h0;
    end else begin
      divCnt_reg <= divCnt_reg + 8'h01;
      if (divCnt_reg == 8'hFF) intClk_reg <= ~intClk_reg;
    end
  end

  // RULE18: tick on chosen clock edge
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : genChan
      assign tick[g] = clkSel_reg[g]
        ? (extS2_reg[g] && !extS3_reg[g])
        : (divCnt_reg == 8'hFF && !intClk_reg[g]);
      // RULE14: 16-bit word per channel
      // RULE15: offset binary passed as-is
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          code_reg[16*g +: 16] <= 16'h0000;
          take_reg[g] <= 1'b0;
          marker_reg[g] <= 1'b0;
        end else begin
          take_reg[g] <= tick[g] && play_reg[g] && !calActive;
          if (tick[g] && play_reg[g] && !calActive)
            code_reg[16*g +: 16] <= bufWord[16*g +: 16];
          // RULE6: one-cycle marker
          marker_reg[g] <= tick[g] && play_reg[g] && !calActive
            && firstSample[g];
        end
      end
      // RULE7: polarity select
      assign front.marker[g] = marker_reg[g] ^ cfg_reg[g][`COSC_CFG_MARK_POL];
    end
  endgenerate

  assign sampleTake = take_reg;
  assign dacOut.code = code_reg;
  assign dacOut.load = take_reg;
  // RULE11: closed unless disconnected
  assign front.connect = ~disc_reg;
  // RULE13: monitor internal clock
  assign front.clockMon = intClk_reg;
  // RULE10: software override
  assign front.lamp = lamp_reg[`COSC_LAMP_FORCE]
    ? lamp_reg[`COSC_LAMP_VALUE] : lampAuto;
  // RULE16: one-of-four select
  assign calMuxSel = calMux_reg;

  // read data registered in setup phase
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (hit(paddr, 12'(`COSC_OFS_CHAN_CFG0 + 2 * i)))
        rdMux = {16'h0000, cfg_reg[i]};
      if (hit(paddr, 12'(`COSC_OFS_CHAN_TEST0 + 4 * i)))
        rdMux = {31'h0, ~selfTest_reg[i]};
    end
    if (hit(paddr, `COSC_OFS_SELF_TEST)) rdMux = {28'h0, selfTest_reg};
    if (hit(paddr, `COSC_OFS_SW_RESET)) rdMux = {16'h0000, swReset_reg};
    if (hit(paddr, `COSC_OFS_GEN_TEST)) rdMux = {31'h0, genTest_reg};
    if (hit(paddr, `COSC_OFS_CONTROL)) rdMux = {24'h0, play_reg, 4'h0};
    if (hit(paddr, `COSC_OFS_LAMP)) rdMux = {28'h0, lamp_reg};
    if (hit(paddr, `COSC_OFS_DISCONNECT)) rdMux = {28'h0, disc_reg};
    if (hit(paddr, `COSC_OFS_CLOCK_SEL)) rdMux = {28'h0, clkSel_reg};
    if (hit(paddr, `COSC_OFS_CAL_MUX)) rdMux = {30'h0, calMux_reg};
    if (hit(paddr, `COSC_OFS_IRQ_STATUS)) rdMux = {29'h0, irqStat_reg};
    if (hit(paddr, `COSC_OFS_IRQ_MASK)) rdMux = {29'h0, irqMask_reg};
    if (hit(paddr, `COSC_OFS_STATE)) rdMux = {28'h0, state_reg};
    // RULE17: fixed read in calibration
    if (calActive) rdMux = `COSC_CAL_READ_VAL;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) prdata <= 32'h0000_0000;
    else if (rdEn) prdata <= rdMux;
  end
endmodule // cosc_channel_output_status_control
`default_nettype wire

// [bench/cosc_channel_output_status_control_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module cosc_channel_output_status_control_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched ports
  input wire logic [63:0] bufWord,
  input wire logic [3:0] firstSample,
  input wire logic [3:0] sampleTake,
  input wire cosc_pkg::cosc_dac_s dacOut,
  input wire cosc_pkg::cosc_front_s front
);
  import cosc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_OFFLINE: assert property ($rose(rstn) |-> front.connect == 4'h0)
    else $error("channels online after reset");
  AST_LAMP_ON: assert property ($rose(rstn) |-> front.lamp)
    else $error("lamp dark after reset");
  AST_MARK_ONE: assert property (
    $changed(front.marker[0]) && sampleTake[0] |=> $changed(front.marker[0]))
    else $error("marker pulse not one cycle");
  AST_MARK_NONE: assert property (
    sampleTake[1] && !$past(firstSample[1]) |-> $stable(front.marker[1]))
    else $error("marker without first sample");
  AST_MARK_HIT: assert property (
    sampleTake[2] && $past(firstSample[2]) |-> $changed(front.marker[2]))
    else $error("marker missing at first sample");
  AST_LOAD: assert property (
    dacOut.load[2] |-> dacOut.code[47:32] == $past(bufWord[47:32]))
    else $error("load without buffer word");
  AST_CODE: assert property (
    dacOut.load[3] |-> dacOut.code[63:48] == $past(bufWord[63:48]))
    else $error("code altered on the way");
  AST_HOLD: assert property (
    !dacOut.load[0] |-> $stable(dacOut.code[15:0]))
    else $error("code moved without load");
  AST_PULSE: assert property (sampleTake[1] |=> !sampleTake[1])
    else $error("take wider than one cycle");
  AST_MON: assert property (
    $changed(front.clockMon[0]) |=> $stable(front.clockMon[0]) [*8])
    else $error("monitor clock too fast");
  cover property (dacOut.load[0] && front.marker[0]);
  cover property ($rose(front.clockMon[1]));
  cover property ($fell(front.lamp));
endmodule // cosc_channel_output_status_control_asserts
bind cosc_channel_output_status_control
  cosc_channel_output_status_control_asserts chk_u (.clk(clk), .rstn(rstn),
  .bufWord(bufWord), .firstSample(firstSample), .sampleTake(sampleTake),
  .dacOut(dacOut), .front(front));
`default_nettype wire

// [bench/cosc_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module cosc_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench control
  input wire logic extRun,
  input wire logic [4:0] faultSet,
  // block side
  input wire logic [3:0] sampleTake,
  output logic [63:0] bufWord,
  output logic [3:0] firstSample,
  output logic [3:0] extClkPin,
  output logic [3:0] chanFault,
  output logic genFault
);
  logic [1:0] ptr [4];
  // three-word table with both code extremes
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      bufWord[16*g +: 16] = ptr[g] == 2'd0 ? 16'h0000 :
        ptr[g] == 2'd1 ? 16'hffff : 16'h1230 + 16'(g);
      firstSample[g] = ptr[g] == 2'd0;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    for (int g = 0; g < 4; g++) begin
      if (!rstn) ptr[g] <= 2'd0;
      else if (sampleTake[g]) ptr[g] <= ptr[g] == 2'd2 ? 2'd0 : ptr[g] + 2'd1;
    end
  end
  // free clocks, phase unrelated to clk; still when idle
  initial extClkPin = 4'h0;
  always #23 extClkPin = extRun ? ~extClkPin : 4'h0;
  assign chanFault = faultSet[3:0];
  assign genFault = faultSet[4];
endmodule // cosc_far_side
`default_nettype wire

// [bench/cosc_channel_output_status_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "cosc_map.svh"
module cosc_channel_output_status_control_tb_top;
  import cosc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, extRun = 1'b0, pready, pslverr, irq, genFault;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [63:0] bufWord;
  logic [3:0] firstSample, sampleTake, extClkPin, chanFault, pol = 4'h0;
  logic [4:0] faultSet = 5'h00;
  logic [1:0] calMuxSel;
  cosc_dac_s dacOut;
  cosc_front_s front;
  int error_cnt = 0, samples_checked = 0, v, dv, hi;
  int ptr[4] = '{0, 0, 0, 0}, nTake[4] = '{0, 0, 0, 0};
  always #4 clk = ~clk;
  cosc_channel_output_status_control #(.BLINK_CYC(4), .TEST_CYC(4)) dut_u (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bufWord(bufWord), .firstSample(firstSample),
    .sampleTake(sampleTake), .extClkPin(extClkPin), .chanFault(chanFault),
    .genFault(genFault), .dacOut(dacOut), .front(front),
    .calMuxSel(calMuxSel), .irq(irq));
  cosc_far_side far_u (.clk(clk), .rstn(rstn), .extRun(extRun),
    .faultSet(faultSet), .sampleTake(sampleTake), .bufWord(bufWord),
    .firstSample(firstSample), .extClkPin(extClkPin), .chanFault(chanFault),
    .genFault(genFault));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a read compares against d
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (!w) chk(prdata, d);
    if (n >= 50) error_cnt++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic lamp(input int e);
    @(negedge clk);
    chk(32'(front.lamp), 32'(e));
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // reference model of the sample path
  always @(negedge clk) begin
    for (int g = 0; g < 4; g++) begin
      if (rstn && dacOut.load[g] === 1'b1) begin
        chk(32'(dacOut.code[16*g +: 16]), ptr[g] == 0 ? 32'h0000_0000 :
          ptr[g] == 1 ? 32'h0000_ffff : 32'h0000_1230 + 32'(g));
        chk(32'(front.marker[g]), 32'(pol[g] ^ (ptr[g] == 0)));
        ptr[g] = (ptr[g] + 1) % 3;
        nTake[g]++;
      end
    end
  end
  initial begin
    #80_000;
    error_cnt++;
    test_done;
  end
  initial begin
    void'($urandom(32'hf2ec_83bd));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    lamp(1);
    chk(32'(front.connect), 32'h0);
    apb(1'b0, `COSC_OFS_STATE, 32'h0000_0002);
    apb(1'b0, `COSC_OFS_SW_RESET, 32'h0000_001d);
    apb(1'b0, `COSC_OFS_DISCONNECT, 32'h0000_000f);
    repeat (8) @(posedge clk);
    apb(1'b0, `COSC_OFS_SELF_TEST, 32'h0000_000f);
    lamp(0);
    $display("test reset done");
    faultSet <= 5'h14;
    apb(1'b1, `COSC_OFS_CONTROL, 32'h0000_0001);
    repeat (10) @(posedge clk);
    apb(1'b0, `COSC_OFS_SELF_TEST, 32'h0000_000b);
    apb(1'b0, `COSC_OFS_GEN_TEST, 32'h0000_0001);
    for (v = 0; v < 4; v++)
      apb(1'b0, 12'(`COSC_OFS_CHAN_TEST0 + 4 * v), 32'(v == 2));
    lamp(1);
    apb(1'b0, `COSC_OFS_IRQ_STATUS, 32'h0000_0003);
    apb(1'b1, `COSC_OFS_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'h1);
    apb(1'b1, `COSC_OFS_IRQ_STATUS, 32'h0000_0003);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'h0);
    for (v = 1; v < 4; v += 2) begin
      apb(1'b1, `COSC_OFS_LAMP, 32'(v));
      lamp(v >> 1);
    end
    apb(1'b1, `COSC_OFS_LAMP, 32'h0000_0000);
    for (v = 0; v < 4; v++) begin
      dv = $urandom % 16;
      apb(1'b1, `COSC_OFS_DISCONNECT, 32'(dv));
      @(negedge clk);
      chk(32'(front.connect), 32'(~dv & 15));
      apb(1'b1, `COSC_OFS_CAL_MUX, 32'(v));
      @(negedge clk);
      chk(32'(calMuxSel), 32'(v));
    end
    $display("test status done");
    faultSet <= 5'h00;
    apb(1'b1, `COSC_OFS_CONTROL, 32'h0000_0001);
    repeat (10) @(posedge clk);
    lamp(0);
    apb(1'b1, `COSC_OFS_CONTROL, 32'h0000_0002);
    apb(1'b0, `COSC_OFS_STATE, 32'h0000_3c00);
    apb(1'b1, `COSC_OFS_DISCONNECT, $urandom);
    hi = 0;
    repeat (16) begin
      @(negedge clk);
      hi += front.lamp;
    end
    chk(32'(hi > 0 && hi < 16), 32'h1);
    apb(1'b1, `COSC_OFS_CONTROL, 32'h0000_0004);
    repeat (2) lamp(0);
    apb(1'b0, `COSC_OFS_DISCONNECT, 32'(dv));
    $display("test calibration done");
    extRun <= 1'b1;
    apb(1'b1, `COSC_OFS_CLOCK_SEL, 32'h0000_000e);
    for (v = 0; v < 2; v++) begin
      apb(1'b1, `COSC_OFS_CONTROL, 32'h0000_00f0);
      repeat (1600) @(posedge clk);
      // stop first so no take meets the polarity change
      apb(1'b1, `COSC_OFS_CONTROL, 32'h0000_0000);
      repeat (4) @(posedge clk);
      apb(1'b1, `COSC_OFS_CHAN_CFG0, 32'h0000_0001);
      pol[0] = 1'b1;
      repeat (3) @(negedge clk);
      chk(32'(front.marker[0]), 32'h1);
    end
    chk(32'(nTake[0] > 3 && nTake[0] < 10 && nTake[1] > 100), 32'h1);
    extRun <= 1'b0;
    $display("test playback done");
    test_done;
  end
endmodule // cosc_channel_output_status_control_tb_top
`default_nettype wire
